// *** hw/dsc_core.sv ***
// Device side of a four-bank DDR SDRAM pin interface, two decks.
// Assumes pins synchronous to mclk; a mclk rising edge stands for the
// positive clock crossing; each data pin carries a rise and fall beat.
//
// Summary of operation
// [R1] Address and control pins are sampled only on the positive crossing.
// [R2] Read data goes out on both clock halves, two beats per cycle.
// [R3] Clock gate high runs clocks, buffers and drivers; low stops them.
// [R4] Gate low: idle banks give power-down or self-refresh, else active PD.
// [R5] Gate registered for PD entry and exit, and for refresh entry and exit.
// [R6] Controller holds the clock gate high through every read and write.
// [R7] Power-down ignores inputs but clock and gate; self-refresh all but gate.
// [R8] Commands with the active-low device select high are ignored.
// [R9] Command decoded from select and three strobes on one edge.
// [R10] Write mask sampled per beat; masked beats are discarded.
// [R11] Write mask is ignored during reads.
// [R12] Bank select picks the bank for activate, read, write, precharge.
// [R13] Bank select picks base or extended mode register on mode loads.
// [R14] Activate takes the row; read and write take column and auto-precharge.
// [R15] Precharge hits the selected bank, or all four banks of that deck with bit ten high.
// [R16] Mode load stores the opcode from the address pins.
// [R17] Strobe edge-aligned with read data; write data captured with strobe.
// [R18] Low strobe covers data bits 0-7, high strobe bits 8-15.
// [R19] Second select and clock gate drive an independent upper deck.
// [R20] Burst length of two, four or eight locations is programmable.
// [R21] Auto-precharge closes the accessed row when its burst ends.
// [R22] Data and strobe are driven only during read bursts.
`include "dsc_consts.svh"
module dsc_core
   import dsc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Deck clock gates and selects
   input wire logic clockGateLowerDeck,
   input wire logic clockGateUpperDeck,
   input wire logic deviceSelectLowerDeck_n,
   input wire logic deviceSelectUpperDeck_n,
   // Command strobes, bank and address
   input wire logic rowStrobe_n,
   input wire logic colStrobe_n,
   input wire logic writeStrobe_n,
   input wire logic bankSelectBit0,
   input wire logic bankSelectBit1,
   input wire logic [`DSC_ADDR_W-1:0] addr,
   // Write data, mask and strobes
   input wire logic [2*`DSC_LANE_W-1:0] dqInRise,
   input wire logic [2*`DSC_LANE_W-1:0] dqInFall,
   input wire logic [1:0] writeByteMaskRise,
   input wire logic [1:0] writeByteMaskFall,
   input wire logic lowByteStrobeIn,
   input wire logic highByteStrobeIn,
   // Read data and strobes
   output logic [2*`DSC_LANE_W-1:0] dqOutRise,
   output logic [2*`DSC_LANE_W-1:0] dqOutFall,
   output logic [1:0] dqOe,
   output logic [1:0] strobeOut,
   output logic [1:0] strobeOe,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData
);

   dsc_pwr_t pwr [2];
   dsc_bst_t bstState;
   dsc_cmd_t cmd;
   logic upperFitted;
   logic [1:0] ckeEff;
   logic [1:0] csPinN;
   logic [1:0] deckSel;
   logic [1:0] srefReq;
   logic [1:0] deckIdle;
   logic [1:0] bankSel;
   logic cmdAccept;
   logic cmdDeck;
   logic [2:0] tgt;
   logic rwOk;
   logic [7:0] bankOpen;
   logic [7:0] bankAct;
   logic [7:0] bankPre;
   logic [`DSC_ADDR_W-1:0] bankRow [8];
   logic [`DSC_ADDR_W-1:0] modeReg [2];
   logic [`DSC_ADDR_W-1:0] extModeReg [2];
   logic [2:0] bstTgt;
   logic [1:0] bstRow;
   logic [`DSC_COL_W-1:0] bstCol;
   logic [`DSC_COL_W-1:0] bstBeat;
   logic [`DSC_COL_W-1:0] bstLen;
   logic [`DSC_COL_W-1:0] nextLen;
   logic bstAutoPre;
   logic burstLast;
   logic autoPreNow;
   logic readOn;
   logic writeOn;
   logic [`DSC_MEM_AW-1:0] addrRise;
   logic [`DSC_MEM_AW-1:0] addrFall;

   // Burst length from the mode register burst code
   function automatic logic [`DSC_COL_W-1:0] burstLen(input logic [2:0] code);
      logic [`DSC_COL_W-1:0] len;
      len = 4'h2;
      if (code == `DSC_BL_CODE_4) begin
         len = 4'h4;
      end else if (code == `DSC_BL_CODE_8) begin
         len = 4'h8;
      end
      return len;
   endfunction : burstLen

   // Column of one beat, wrapping inside the burst-aligned block
   function automatic logic [`DSC_COL_W-1:0] beatCol(
      input logic [`DSC_COL_W-1:0] base,
      input logic [`DSC_COL_W-1:0] beat,
      input logic [`DSC_COL_W-1:0] len
   );
      logic [`DSC_COL_W-1:0] msk;
      msk = 4'(len - 4'h1);
      return (base & ~msk) | (4'(base + beat) & msk);
   endfunction : beatCol

   // Upper deck gate counts only when the stacked variant is fitted
   assign ckeEff[0] = clockGateLowerDeck; // R3
   assign ckeEff[1] = upperFitted ? clockGateUpperDeck : 1'b1; // R19
   assign csPinN = {deviceSelectUpperDeck_n, deviceSelectLowerDeck_n};
   assign bankSel = {bankSelectBit1, bankSelectBit0};
   assign cmd = dsc_cmd_t'({rowStrobe_n, colStrobe_n, writeStrobe_n}); // R9

   // A deck listens only when selected, gated on and fully awake
   assign deckSel[0] = !csPinN[0] && ckeEff[0] && // R8 R7
      pwr[0] == PWR_ACTIVE;
   assign deckSel[1] = upperFitted && !csPinN[1] && ckeEff[1] && // R19
      pwr[1] == PWR_ACTIVE && !deckSel[0];
   assign cmdAccept = |deckSel; // R1
   assign cmdDeck = deckSel[1];
   assign tgt = {cmdDeck, bankSel}; // R12
   assign rwOk = cmdAccept && (cmd == CMD_RD || cmd == CMD_WR) &&
      bankOpen[tgt];
   assign nextLen = burstLen(modeReg[cmdDeck][`DSC_BL_MSB:`DSC_BL_LSB]);

   // Self-refresh request and idle banks per deck
   assign srefReq[0] = !csPinN[0] && cmd == CMD_REF;
   assign srefReq[1] = upperFitted && !csPinN[1] && cmd == CMD_REF;
   assign deckIdle = {~|bankOpen[7:4], ~|bankOpen[3:0]};

   // Bank command pulses, including the self-timed auto-precharge
   always_comb begin
      bankAct = '0;
      bankPre = '0;
      if (cmdAccept && cmd == CMD_ACT) begin
         bankAct[tgt] = 1'b1; // R12 R14
      end
      if (cmdAccept && cmd == CMD_PRE) begin
         if (addr[`DSC_PRE_ALL_BIT]) begin // R15
            if (cmdDeck) begin
               bankPre[7:4] = 4'hF;
            end else begin
               bankPre[3:0] = 4'hF;
            end
         end else begin
            bankPre[tgt] = 1'b1; // R15
         end
      end
      if (autoPreNow) begin
         bankPre[bstTgt] = 1'b1; // R21
      end
   end

   // Four banks per deck
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : gBank
         dsc_bank uBank (
            .mclk(mclk),
            .reset_n(reset_n),
            .activate(bankAct[g]),
            .precharge(bankPre[g]),
            .rowIn(addr),
            .isOpen(bankOpen[g]),
            .openRow(bankRow[g])
         );
      end
   endgenerate

   // Mode loads: bank select picks base or extended register
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         modeReg[0] <= `DSC_MODE_RESET;
         modeReg[1] <= `DSC_MODE_RESET;
         extModeReg[0] <= `DSC_EXT_RESET;
         extModeReg[1] <= `DSC_EXT_RESET;
      end else if (cmdAccept && cmd == CMD_MRS) begin
         if (bankSel == `DSC_MRS_BASE) begin // R13
            modeReg[cmdDeck] <= addr; // R16
         end else if (bankSel == `DSC_MRS_EXT) begin // R13
            extModeReg[cmdDeck] <= addr; // R16
         end
      end
   end

   // Power state per deck, gate sampled at each rising mclk edge
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pwr[0] <= PWR_ACTIVE;
         pwr[1] <= PWR_ACTIVE;
      end else begin
         for (int d = 0; d < 2; d++) begin
            case (pwr[d])
               PWR_ACTIVE: begin
                  if (!ckeEff[d]) begin // R5
                     if (srefReq[d] && deckIdle[d]) begin
                        pwr[d] <= PWR_SREF; // R4
                     end else if (deckIdle[d]) begin
                        pwr[d] <= PWR_PRE_PD; // R4
                     end else begin
                        pwr[d] <= PWR_ACT_PD; // R4
                     end
                  end
               end
               PWR_PRE_PD, PWR_ACT_PD: begin
                  if (ckeEff[d]) begin // R5
                     pwr[d] <= PWR_ACTIVE;
                  end
               end
               PWR_SREF: begin
                  if (ckeEff[d]) begin // R5 R7
                     pwr[d] <= PWR_ACTIVE;
                  end
               end
               default: begin
                  pwr[d] <= PWR_ACTIVE;
               end
            endcase
         end
      end
   end

   // Burst engine: two locations per cycle until the programmed length
   assign burstLast = bstState != BST_IDLE &&
      4'(bstBeat + 4'h2) >= bstLen; // R20
   assign autoPreNow = burstLast && bstAutoPre; // R21

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         bstState <= BST_IDLE;
         bstTgt <= '0;
         bstRow <= '0;
         bstCol <= '0;
         bstBeat <= '0;
         bstLen <= 4'h2;
         bstAutoPre <= 1'b0;
      end else if (rwOk) begin
         bstState <= (cmd == CMD_RD) ? BST_READ : BST_WRITE;
         bstTgt <= tgt; // R12
         bstRow <= bankRow[tgt][1:0];
         bstCol <= addr[`DSC_COL_W-1:0]; // R14
         bstBeat <= '0;
         bstLen <= nextLen; // R20
         bstAutoPre <= addr[`DSC_AUTO_PRE_BIT]; // R14
      end else if (bstState != BST_IDLE) begin
         bstBeat <= 4'(bstBeat + 4'h2);
         if (burstLast) begin
            bstState <= BST_IDLE;
         end
      end
   end

   // Beat addresses and lane enables; gate low stops buffers and drivers
   assign addrRise = {bstTgt, bstRow, beatCol(bstCol, bstBeat, bstLen)};
   assign addrFall = {bstTgt, bstRow,
      beatCol(bstCol, 4'(bstBeat + 4'h1), bstLen)};
   assign readOn = bstState == BST_READ && ckeEff[bstTgt[2]]; // R3 R6
   assign writeOn = bstState == BST_WRITE && ckeEff[bstTgt[2]]; // R3 R11

   // Low lane carries bits 0-7 with the low strobe
   dsc_lane uLaneLow (
      .mclk(mclk),
      .reset_n(reset_n),
      .writeOn(writeOn),
      .strobe(lowByteStrobeIn), // R18
      .maskRise(writeByteMaskRise[0]),
      .maskFall(writeByteMaskFall[0]),
      .addrRise(addrRise),
      .addrFall(addrFall),
      .dataRise(dqInRise[`DSC_LANE_W-1:0]),
      .dataFall(dqInFall[`DSC_LANE_W-1:0]),
      .readOn(readOn),
      .qRise(dqOutRise[`DSC_LANE_W-1:0]),
      .qFall(dqOutFall[`DSC_LANE_W-1:0])
   );

   // High lane carries bits 8-15 with the high strobe
   dsc_lane uLaneHigh (
      .mclk(mclk),
      .reset_n(reset_n),
      .writeOn(writeOn),
      .strobe(highByteStrobeIn), // R18
      .maskRise(writeByteMaskRise[1]),
      .maskFall(writeByteMaskFall[1]),
      .addrRise(addrRise),
      .addrFall(addrFall),
      .dataRise(dqInRise[2*`DSC_LANE_W-1:`DSC_LANE_W]),
      .dataFall(dqInFall[2*`DSC_LANE_W-1:`DSC_LANE_W]),
      .readOn(readOn),
      .qRise(dqOutRise[2*`DSC_LANE_W-1:`DSC_LANE_W]),
      .qFall(dqOutFall[2*`DSC_LANE_W-1:`DSC_LANE_W])
   );

   // Drivers and strobe follow read data; strobe high in the rise half
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dqOe <= 2'h0;
         strobeOut <= 2'h0;
         strobeOe <= 2'h0;
      end else begin
         dqOe <= {2{readOn}}; // R22
         strobeOut <= {2{readOn}}; // R17 R2
         strobeOe <= {2{readOn}}; // R22
      end
   end

   // Control register write
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         upperFitted <= 1'b0;
      end else if (regWr && regAddr == `DSC_REG_CTRL) begin
         upperFitted <= regWrData[`DSC_CTRL_UPPER_BIT]; // R19
      end
   end

   // Register read, data valid in the cycle after the strobe
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         regRdData <= 32'h0;
      end else if (!regRd) begin
         regRdData <= 32'h0;
      end else if (regAddr == `DSC_REG_CTRL) begin
         regRdData <= {31'h0, upperFitted};
      end else if (regAddr == `DSC_REG_STATUS) begin
         regRdData <= {13'h0, bstState, bankOpen, pwr[1], pwr[0]};
      end else if (regAddr == `DSC_REG_MODE) begin
         regRdData <= {3'h0, modeReg[1], 3'h0, modeReg[0]};
      end else if (regAddr == `DSC_REG_EXTMODE) begin
         regRdData <= {3'h0, extModeReg[1], 3'h0, extModeReg[0]};
      end else begin
         regRdData <= 32'h0;
      end
   end

   // Checks
   default clocking cbDsc @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   sequence sReadCmd;
      rwOk && cmd == CMD_RD;
   endsequence
   sequence sReadOut;
      dqOe == 2'h3 && strobeOut == 2'h3 && strobeOe == 2'h3;
   endsequence
   sequence sWrite8;
      rwOk && cmd == CMD_WR && nextLen == 4'h8;
   endsequence

   AST_READ_DRIVE: assert property ( // R2
      sReadCmd ##1 clockGateLowerDeck && clockGateUpperDeck |=> sReadOut)
      else $error("read burst did not drive data and strobe");
   AST_OE_READ_ONLY: assert property ( // R22
      dqOe != 2'h0 |-> $past(bstState) == BST_READ)
      else $error("data driven outside a read burst");
   AST_DESELECT: assert property ( // R8
      csPinN == 2'h3 && bstState == BST_IDLE |=> $stable(bankOpen))
      else $error("bank state changed while deselected");
   AST_PD_IDLE: assert property ( // R4
      pwr[0] == PWR_ACTIVE && !clockGateLowerDeck && deckIdle[0] &&
      !srefReq[0] |=> pwr[0] == PWR_PRE_PD)
      else $error("idle deck missed precharge power-down");
   AST_PD_ACTIVE: assert property ( // R4
      pwr[0] == PWR_ACTIVE && !clockGateLowerDeck && !deckIdle[0]
      |=> pwr[0] == PWR_ACT_PD)
      else $error("open deck missed active power-down");
   AST_SREF_EXIT: assert property ( // R5
      pwr[0] == PWR_SREF && clockGateLowerDeck |=> pwr[0] == PWR_ACTIVE)
      else $error("self-refresh exit not taken");
   AST_PD_QUIET: assert property ( // R7
      pwr[0] != PWR_ACTIVE |-> !deckSel[0])
      else $error("command taken during power-down");
   AST_PRE_ALL: assert property ( // R15
      cmdAccept && cmd == CMD_PRE && addr[`DSC_PRE_ALL_BIT] && !cmdDeck
      |=> bankOpen[3:0] == 4'h0)
      else $error("precharge all left a bank open");
   AST_EXT_LOAD: assert property ( // R13
      cmdAccept && cmd == CMD_MRS && !cmdDeck && bankSel == `DSC_MRS_EXT
      |=> extModeReg[0] == $past(addr) && $stable(modeReg[0]))
      else $error("extended mode load went astray");
   AST_BURST8: assert property ( // R20
      sWrite8 ##1 (!rwOk && bstState == BST_WRITE) [*4]
      |=> bstState == BST_IDLE)
      else $error("burst of eight did not end after four cycles");

endmodule : dsc_core

// *** include/dsc_consts.svh ***
// Constants for the DDR pin command interface: register offsets, field
// positions, reset values and widths.
// Assumes inclusion by design files that also import dsc_pkg.
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH

// Pin and storage widths
`define DSC_ADDR_W 13
`define DSC_LANE_W 8
`define DSC_MEM_AW 9
`define DSC_COL_W 4

// Address bit positions
`define DSC_PRE_ALL_BIT 10
`define DSC_AUTO_PRE_BIT 10

// Mode register burst field and codes
`define DSC_BL_LSB 0
`define DSC_BL_MSB 2
`define DSC_BL_CODE_2 3'h1
`define DSC_BL_CODE_4 3'h2
`define DSC_BL_CODE_8 3'h3
`define DSC_MODE_RESET 13'h0001
`define DSC_EXT_RESET 13'h0000

// Bank select values during a mode load
`define DSC_MRS_BASE 2'h0
`define DSC_MRS_EXT 2'h1

// Register port offsets
`define DSC_REG_CTRL 8'h00
`define DSC_REG_STATUS 8'h04
`define DSC_REG_MODE 8'h08
`define DSC_REG_EXTMODE 8'h0C
`define DSC_CTRL_UPPER_BIT 0

`endif

// *** include/dsc_pkg.sv ***
// Types for the DDR pin command interface.
// Assumes nothing beyond a SystemVerilog compiler.
package dsc_pkg;

   // Command code from {row strobe, column strobe, write strobe}
   typedef enum logic [2:0] {
      CMD_MRS = 3'h0,
      CMD_REF = 3'h1,
      CMD_PRE = 3'h2,
      CMD_ACT = 3'h3,
      CMD_WR = 3'h4,
      CMD_RD = 3'h5,
      CMD_BST = 3'h6,
      CMD_NOP = 3'h7
   } dsc_cmd_t;

   // Power state of one deck
   typedef enum logic [3:0] {
      PWR_ACTIVE = 4'b0001,
      PWR_PRE_PD = 4'b0010,
      PWR_ACT_PD = 4'b0100,
      PWR_SREF = 4'b1000
   } dsc_pwr_t;

   // Data burst engine state
   typedef enum logic [2:0] {
      BST_IDLE = 3'b001,
      BST_READ = 3'b010,
      BST_WRITE = 3'b100
   } dsc_bst_t;

endpackage : dsc_pkg

// *** hw/dsc_bank.sv ***
// Row tracker for one bank: open flag and the open row address.
// Assumes activate and precharge are one-cycle pulses on mclk.
`include "dsc_consts.svh"
module dsc_bank
   import dsc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Bank commands
   input wire logic activate,
   input wire logic precharge,
   input wire logic [`DSC_ADDR_W-1:0] rowIn,
   // Bank state
   output logic isOpen,
   output logic [`DSC_ADDR_W-1:0] openRow
);

   // Activate opens a row, precharge closes it; activate wins a tie
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         isOpen <= 1'b0;
         openRow <= '0;
      end else if (activate) begin
         isOpen <= 1'b1;
         openRow <= rowIn;
      end else if (precharge) begin
         isOpen <= 1'b0;
      end
   end

endmodule : dsc_bank

// *** hw/dsc_lane.sv ***
// One byte lane: storage array, masked double-rate write, read registers.
// Assumes two beats per mclk cycle, rise beat first.
`include "dsc_consts.svh"
module dsc_lane
   import dsc_pkg::*;
#(
   parameter int WIDTH = `DSC_LANE_W,
   parameter int AW = `DSC_MEM_AW
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Write side
   input wire logic writeOn,
   input wire logic strobe,
   input wire logic maskRise,
   input wire logic maskFall,
   input wire logic [AW-1:0] addrRise,
   input wire logic [AW-1:0] addrFall,
   input wire logic [WIDTH-1:0] dataRise,
   input wire logic [WIDTH-1:0] dataFall,
   // Read side
   input wire logic readOn,
   output logic [WIDTH-1:0] qRise,
   output logic [WIDTH-1:0] qFall
);

   logic [WIDTH-1:0] mem [2**AW];

   // Strobe captures a beat; a high mask sample discards it
   always_ff @(posedge mclk) begin
      if (writeOn && strobe && !maskRise) begin // R10 R17
         mem[addrRise] <= dataRise;
      end
      if (writeOn && strobe && !maskFall) begin // R10
         mem[addrFall] <= dataFall;
      end
   end

   // Read beats registered for both halves of the clock
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         qRise <= '0;
         qFall <= '0;
      end else if (readOn) begin // R2
         qRise <= mem[addrRise];
         qFall <= mem[addrFall];
      end else begin
         qRise <= '0;
         qFall <= '0;
      end
   end

endmodule : dsc_lane

// *** verif/dsc_ctl_model.sv ***
// Memory controller model: drives command, address and write-data pins.
// Assumes the bench calls one task per pin cycle, in order.
module dsc_ctl_model
   import dsc_pkg::*;
(
   // Clock
   input wire logic mclk,
   // Gates and selects
   output logic clockGateLowerDeck,
   output logic clockGateUpperDeck,
   output logic deviceSelectLowerDeck_n,
   output logic deviceSelectUpperDeck_n,
   // Command, bank and address
   output logic rowStrobe_n,
   output logic colStrobe_n,
   output logic writeStrobe_n,
   output logic bankSelectBit0,
   output logic bankSelectBit1,
   output logic [12:0] addr,
   // Write data, masks and strobes
   output logic [15:0] dqInRise,
   output logic [15:0] dqInFall,
   output logic [1:0] writeByteMaskRise,
   output logic [1:0] writeByteMaskFall,
   output logic lowByteStrobeIn,
   output logic highByteStrobeIn
);
   timeunit 1ns;
   timeprecision 1ns;
   // Known pin levels at time zero; upper deck stays deselected
   initial begin
      clockGateLowerDeck = 1'b1;
      clockGateUpperDeck = 1'b1;
      deviceSelectLowerDeck_n = 1'b1;
      deviceSelectUpperDeck_n = 1'b1;
      {rowStrobe_n, colStrobe_n, writeStrobe_n} = CMD_NOP;
      {bankSelectBit1, bankSelectBit0} = 2'h0;
      addr = 13'h0000;
      dqInRise = 16'h0000;
      dqInFall = 16'h0000;
      writeByteMaskRise = 2'h0;
      writeByteMaskFall = 2'h0;
      {lowByteStrobeIn, highByteStrobeIn} = 2'h0;
   end

   // One pin cycle, select, command, address and write pins set once at the edge
   task automatic drive(input logic selN, input dsc_cmd_t cmd,
         input logic [1:0] bank, input logic [12:0] a,
         input logic [15:0] r, f, input logic [1:0] mr, mf, stb);
      @(posedge mclk);
      deviceSelectLowerDeck_n <= selN;
      {rowStrobe_n, colStrobe_n, writeStrobe_n} <= cmd;
      {bankSelectBit1, bankSelectBit0} <= bank;
      addr <= a;
      dqInRise <= r;
      dqInFall <= f;
      writeByteMaskRise <= mr;
      writeByteMaskFall <= mf;
      {highByteStrobeIn, lowByteStrobeIn} <= stb;
   endtask : drive

   // Command cycle; data lines released show a changing pattern
   task automatic issue(input logic selN, input dsc_cmd_t cmd,
         input logic [1:0] bank, input logic [12:0] a);
      drive(selN, cmd, bank, a, ~dqInRise, ~dqInFall,
         ~writeByteMaskRise, ~writeByteMaskFall, 2'h0);
   endtask : issue

   // Write beat pair with both lane strobes, gate left high
   task automatic beat(input logic [15:0] r, f, input logic [1:0] mr, mf);
      drive(1'b1, CMD_NOP, ~{bankSelectBit1, bankSelectBit0}, ~addr,
         r, f, mr, mf, 2'h3);
   endtask : beat

   // Idle cycle, mask toggles to show it is ignored
   task automatic quiet;
      drive(1'b1, CMD_NOP, ~{bankSelectBit1, bankSelectBit0}, ~addr,
         ~dqInRise, ~dqInFall, ~writeByteMaskRise, ~writeByteMaskFall,
         2'h0);
   endtask : quiet

   // Gate change, called right at an edge
   task automatic gate(input logic v);
      clockGateLowerDeck <= v;
   endtask : gate
endmodule : dsc_ctl_model

// *** verif/dsc_core_tb.sv ***
// Bench for the DDR pin command interface, device side.
// Assumes dsc_ctl_model drives the command and write pins.
module dsc_core_tb
   import dsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // Clock, reset, pins and counters
   logic mclk, reset_n;
   logic clockGateLowerDeck, clockGateUpperDeck;
   logic deviceSelectLowerDeck_n, deviceSelectUpperDeck_n;
   logic rowStrobe_n, colStrobe_n, writeStrobe_n;
   logic bankSelectBit0, bankSelectBit1, lowByteStrobeIn, highByteStrobeIn;
   logic [12:0] addr;
   logic [15:0] dqInRise, dqInFall, dqOutRise, dqOutFall;
   logic [1:0] writeByteMaskRise, writeByteMaskFall;
   logic [1:0] dqOe, strobeOut, strobeOe;
   logic regWr, regRd;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData, d;
   int fails, comparisons, cycles;

   dsc_ctl_model ctl (.*);
   dsc_core dut (.*);

   // Compare and count
   task automatic check(input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Register read: data stands in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 v = regRdData;
   endtask : rd

   // Reset values, read-only status, unmapped place
   task automatic t_regs;
      rd(8'h04, d); check(d, 32'h0001_0011);
      rd(8'h08, d); check(d, 32'h0001_0001);
      rd(8'h10, d); check(d, 32'h0000_0000);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= 8'h04;
      regWrData <= 32'hFFFF_FFFF;
      @(posedge mclk);
      regWr <= 1'b0;
      rd(8'h04, d); check(d, 32'h0001_0011);
      // Control bit reads back, then the upper deck is marked absent again
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= 8'h00;
      regWrData <= 32'h0000_0001;
      @(posedge mclk);
      regWr <= 1'b0;
      rd(8'h00, d); check(d, 32'h0000_0001);
      @(posedge mclk);
      regWr <= 1'b1;
      regWrData <= 32'h0000_0000;
      @(posedge mclk);
      regWr <= 1'b0;
      rd(8'h00, d); check(d, 32'h0000_0000);
      $display("regs test done");
   endtask : t_regs

   // Base and extended mode loads back to back, burst four
   task automatic t_mode;
      ctl.issue(1'b0, CMD_MRS, 2'h0, 13'h0002);
      ctl.issue(1'b0, CMD_MRS, 2'h1, 13'h0040);
      ctl.quiet();
      rd(8'h08, d); check(d, 32'h0001_0002);
      rd(8'h0C, d); check(d, 32'h0000_0040);
      $display("mode test done");
   endtask : t_mode

   // Masked writes, deselected read, wrapped read burst
   task automatic t_data;
      ctl.issue(1'b0, CMD_ACT, 2'h2, 13'h0005);
      ctl.issue(1'b0, CMD_WR, 2'h2, 13'h0004);
      ctl.beat(16'h1111, 16'h2222, 2'h0, 2'h0);
      ctl.beat(16'h3333, 16'h4444, 2'h0, 2'h0);
      ctl.issue(1'b0, CMD_WR, 2'h2, 13'h0004);
      ctl.beat(16'hAAAA, 16'hBBBB, 2'h1, 2'h0);
      ctl.beat(16'hCCCC, 16'hDDDD, 2'h0, 2'h2);
      #1 check(32'(dqOe), 32'h0);
      ctl.issue(1'b1, CMD_RD, 2'h2, 13'h0006);
      ctl.quiet();
      ctl.quiet();
      #1 check(32'(dqOe), 32'h0);
      ctl.issue(1'b0, CMD_RD, 2'h2, 13'h0006);
      ctl.quiet();
      ctl.quiet();
      #1 check({dqOutRise, dqOutFall}, 32'hCCCC_44DD);
      check({26'h0, dqOe, strobeOut, strobeOe}, 32'h3F);
      ctl.quiet();
      #1 check({dqOutRise, dqOutFall}, 32'hAA11_BBBB);
      ctl.quiet();
      #1 check({26'h0, dqOe, strobeOut, strobeOe}, 32'h0);
      $display("data test done");
   endtask : t_data

   // Bank precharge, active power-down, self-refresh entry and exit
   task automatic t_power;
      ctl.issue(1'b0, CMD_ACT, 2'h1, 13'h0003);
      ctl.issue(1'b0, CMD_PRE, 2'h1, 13'h0000);
      ctl.quiet();
      rd(8'h04, d); check(d, 32'h0001_0411);
      ctl.quiet();
      ctl.gate(1'b0);
      ctl.quiet();
      ctl.issue(1'b0, CMD_ACT, 2'h3, 13'h0000);
      ctl.quiet();
      rd(8'h04, d); check(d, 32'h0001_0414);
      ctl.quiet();
      ctl.gate(1'b1);
      ctl.quiet();
      rd(8'h04, d); check(d, 32'h0001_0411);
      ctl.issue(1'b0, CMD_PRE, 2'h0, 13'h0400);
      ctl.quiet();
      rd(8'h04, d); check(d, 32'h0001_0011);
      ctl.issue(1'b0, CMD_REF, 2'h0, 13'h0000);
      ctl.gate(1'b0);
      ctl.quiet();
      rd(8'h04, d); check(d, 32'h0001_0018);
      ctl.quiet();
      ctl.gate(1'b1);
      ctl.quiet();
      rd(8'h04, d); check(d, 32'h0001_0011);
      $display("power test done");
   endtask : t_power

   // Counts and verdict
   task automatic close_out;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   // Clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 600) begin
         fails++;
         close_out();
      end
   end

   // Main sequence
   initial begin
      reset_n = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h00;
      regWrData = 32'h0000_0000;
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      t_regs();
      t_mode();
      t_data();
      t_power();
      close_out();
   end
endmodule : dsc_core_tb
